/* File: core/ring_beacon_defs.vh */
// Constants for the ring beacon and hard error recovery control.
// Assumes a 10 MHz station clock; counts derive from the times below.
`ifndef RING_BEACON_DEFS_VH
`define RING_BEACON_DEFS_VH

// ****************************************************
// Clock rate and times
// ****************************************************
`define CLK_KHZ 10000
`define SILENCE_MS 200
`define CONTEND_MS 1000
`define SILENCE_CYC (`SILENCE_MS * `CLK_KHZ)
`define CONTEND_CYC (`CONTEND_MS * `CLK_KHZ)

// ****************************************************
// Line monitor thresholds
// ****************************************************
`define BURST_IDLE_BITS 4
`define LOSS_BITS 16
`define CLK_LOSS_CYC 64

// ****************************************************
// Beacon type codes
// ****************************************************
`define BCN_SIG_LOSS 16'h0002
`define BCN_STREAM 16'h0003
`define BCN_CLAIM_RCVD 16'h0004

// ****************************************************
// Mode codes
// ****************************************************
`define MODE_REPEAT 3'h0
`define MODE_IDLE_TX 3'h1
`define MODE_CONT_TX 3'h2
`define MODE_CONT_RX 3'h3
`define MODE_BCN_TX 3'h4
`define MODE_BCN_RX 3'h5
`define MODE_REMOVED 3'h6
`define MODE_SELFTEST 3'h7

`endif

/* File: core/ring_line_monitor.v */
// Line monitor: samples the recovered bit clock and ring data and
// flags missing transitions. Both inputs are asynchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "ring_beacon_defs.vh"

module ring_line_monitor #(
    parameter BURST_BITS = `BURST_IDLE_BITS,
    parameter LOSS_BITS = `LOSS_BITS,
    parameter CLK_LOSS = `CLK_LOSS_CYC
) (
    input wire sys_clk,
    input wire resetn,
    input wire rx_clk,
    input wire rx_data,
    output reg burst_r,
    output reg signal_loss_r
);

    reg [1:0] clk_sync_r;
    reg [1:0] dat_sync_r;
    reg clk_prev_r;
    reg dat_prev_r;
    reg [7:0] miss_r;
    reg [7:0] idle_r;
    wire clk_rise;

    // ****************************************************
    // Two-stage synchronisers; only stage two is read
    // ****************************************************
    always @(posedge sys_clk) begin
        if (!resetn) begin
            clk_sync_r <= 2'h0;
            dat_sync_r <= 2'h0;
            clk_prev_r <= 1'b0;
            dat_prev_r <= 1'b0;
        end else begin
            clk_sync_r <= {clk_sync_r[0], rx_clk};
            dat_sync_r <= {dat_sync_r[0], rx_data};
            clk_prev_r <= clk_sync_r[1];
            if (clk_rise) begin
                dat_prev_r <= dat_sync_r[1];
            end
        end
    end

    assign clk_rise = clk_sync_r[1] & ~clk_prev_r;

    // ****************************************************
    // Missing transition and dead clock counters
    // ****************************************************
    // A bit period with no data change counts as one missing transition
    always @(posedge sys_clk) begin
        if (!resetn) begin
            miss_r <= 8'h00;
            idle_r <= 8'h00;
            burst_r <= 1'b0;
            signal_loss_r <= 1'b0;
        end else begin
            if (clk_rise) begin
                idle_r <= 8'h00;
                if (dat_sync_r[1] != dat_prev_r) begin
                    miss_r <= 8'h00;
                end else if (miss_r != 8'hFF) begin
                    miss_r <= miss_r + 8'h01;
                end
            end else if (idle_r != 8'hFF) begin
                idle_r <= idle_r + 8'h01;
            end
            burst_r <= (miss_r >= BURST_BITS[7:0]);
            // Loss also when the recovered clock stops altogether
            signal_loss_r <= (miss_r >= LOSS_BITS[7:0]) || (idle_r >= CLK_LOSS[7:0]);
        end
    end

endmodule
`default_nettype wire

/* File: core/ring_beacon_recovery.v */
// Hard error recovery control for a ring station: contention,
// beacon transmit and repeat, removal and reinsertion.
// Assumes frame decode and removal functions on sys_clk give pulses.
`timescale 1ns/100ps
`default_nettype none
`include "ring_beacon_defs.vh"

module ring_beacon_recovery #(
    parameter SILENCE_CYC = `SILENCE_CYC,
    parameter CONTEND_CYC = `CONTEND_CYC
) (
    input wire sys_clk,
    input wire resetn,
    input wire rx_clk,
    input wire rx_data,
    input wire rx_beacon,
    input wire [15:0] rx_beacon_type,
    input wire rx_beacon_own,
    input wire rx_claim,
    input wire rx_purge,
    input wire rx_own_frame,
    input wire contend_start,
    input wire contend_won,
    input wire stream_err,
    input wire claim_stream_err,
    input wire neighbor_load,
    input wire [47:0] neighbor_in,
    input wire tx_remove,
    input wire rx_remove,
    input wire selftest_done,
    input wire selftest_pass,
    input wire reinsert_req,
    output reg [2:0] mode_r,
    output reg send_idle_r,
    output reg send_claim_r,
    output reg send_beacon_r,
    output reg repeat_en_r,
    output reg strip_frame_r,
    output reg purge_accept_r,
    output reg ring_insert_r,
    output reg run_selftest_r,
    output reg signal_loss_r,
    output reg [15:0] beacon_type_r,
    output reg [47:0] beacon_neighbor_r
);

    reg [2:0] mode_nxt;
    reg [15:0] type_nxt;
    reg [31:0] timer_r;
    reg [47:0] upstream_neighbor_address_r;
    reg claim_seen_r;
    reg loss_cause_r;
    reg load_timer;
    reg [31:0] timer_load;
    wire burst;
    wire line_loss;
    wire timer_done;

    // ****************************************************
    // Line monitor on the recovered clock
    // ****************************************************
    ring_line_monitor u_line (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .rx_clk(rx_clk),
        .rx_data(rx_data),
        .burst_r(burst),
        .signal_loss_r(line_loss)
    );

    assign timer_done = (timer_r == 32'h0000_0001);

    // Helper: is this mode one of the two contention modes
    function is_contend;
        input [2:0] m;
        begin
            is_contend = (m == `MODE_CONT_TX) || (m == `MODE_CONT_RX);
        end
    endfunction

    // ****************************************************
    // Mode selection
    // ****************************************************
    // Error entries outrank everything but removal and, in contention, a received beacon, since a fault
    // that keeps firing must not be masked by a stale contention.
    always @* begin
        mode_nxt = mode_r;
        type_nxt = beacon_type_r;
        load_timer = 1'b0;
        timer_load = 32'h0000_0000;
        case (mode_r)
            `MODE_REPEAT: begin
                if (line_loss) begin
                    mode_nxt = `MODE_CONT_TX;
                end else if (burst) begin
                    mode_nxt = `MODE_IDLE_TX;
                end else if (claim_stream_err) begin
                    mode_nxt = `MODE_BCN_TX;
                    type_nxt = `BCN_CLAIM_RCVD;
                end else if (stream_err) begin
                    mode_nxt = `MODE_BCN_TX;
                    type_nxt = `BCN_STREAM;
                end else if (rx_beacon) begin
                    mode_nxt = `MODE_BCN_RX;
                end else if (contend_start) begin
                    mode_nxt = `MODE_CONT_TX;
                end else if (rx_claim) begin
                    mode_nxt = `MODE_CONT_RX;
                end
            end
            `MODE_IDLE_TX: begin
                if (line_loss) begin
                    mode_nxt = `MODE_CONT_TX;
                end else if (!burst) begin
                    mode_nxt = `MODE_REPEAT;
                end
            end
            `MODE_CONT_TX, `MODE_CONT_RX: begin
                // Purge frames are not looked at here
                if (rx_beacon) begin
                    mode_nxt = `MODE_BCN_RX;
                end else if (claim_stream_err) begin
                    mode_nxt = `MODE_BCN_TX;
                    type_nxt = `BCN_CLAIM_RCVD;
                end else if (stream_err) begin
                    mode_nxt = `MODE_BCN_TX;
                    type_nxt = `BCN_STREAM;
                end else if (timer_done) begin
                    mode_nxt = `MODE_BCN_TX;
                    if (loss_cause_r) begin
                        type_nxt = `BCN_SIG_LOSS;
                    end else if (claim_seen_r || rx_claim) begin
                        type_nxt = `BCN_CLAIM_RCVD;
                    end else begin
                        type_nxt = `BCN_STREAM;
                    end
                end else if (contend_won) begin
                    mode_nxt = `MODE_REPEAT;
                end else if (mode_r == `MODE_CONT_RX && contend_start) begin
                    mode_nxt = `MODE_CONT_TX;
                end
            end
            `MODE_BCN_TX: begin
                if (tx_remove) begin
                    mode_nxt = `MODE_REMOVED;
                end else if (rx_beacon && rx_beacon_own) begin
                    mode_nxt = `MODE_CONT_TX;
                end else if (rx_beacon && rx_beacon_type <= beacon_type_r) begin
                    mode_nxt = `MODE_BCN_RX;
                end
                // A higher foreign code leaves us beaconing
            end
            `MODE_BCN_RX: begin
                if (rx_remove) begin
                    mode_nxt = `MODE_SELFTEST;
                end else if (timer_done) begin
                    mode_nxt = `MODE_CONT_TX;
                end
            end
            `MODE_SELFTEST: begin
                if (selftest_done) begin
                    mode_nxt = selftest_pass ? `MODE_REPEAT : `MODE_REMOVED;
                end
            end
            `MODE_REMOVED: begin
                if (reinsert_req) begin
                    mode_nxt = `MODE_SELFTEST;
                end
            end
            default: begin
                mode_nxt = `MODE_REPEAT;
            end
        endcase
        // Timer reload on contention entry or on each repeated beacon
        if (is_contend(mode_nxt) && !is_contend(mode_r)) begin
            load_timer = 1'b1;
            timer_load = CONTEND_CYC;
        end else if (mode_nxt == `MODE_BCN_RX && (mode_r != `MODE_BCN_RX || rx_beacon)) begin
            load_timer = 1'b1;
            timer_load = SILENCE_CYC;
        end
    end

    // ****************************************************
    // Mode, timer and contention history
    // ****************************************************
    always @(posedge sys_clk) begin
        if (!resetn) begin
            mode_r <= `MODE_REPEAT;
            beacon_type_r <= 16'h0000;
            timer_r <= 32'h0000_0000;
            claim_seen_r <= 1'b0;
            loss_cause_r <= 1'b0;
            upstream_neighbor_address_r <= 48'h0000_0000_0000;
            beacon_neighbor_r <= 48'h0000_0000_0000;
        end else begin
            mode_r <= mode_nxt;
            beacon_type_r <= type_nxt;
            if (load_timer) begin
                timer_r <= timer_load;
            end else if (timer_r != 32'h0000_0000) begin
                timer_r <= timer_r - 32'h0000_0001;
            end
            if (neighbor_load) begin
                upstream_neighbor_address_r <= neighbor_in;
            end
            // Suspect is latched once, so later neighbour updates do not move it
            if (mode_nxt == `MODE_BCN_TX && mode_r != `MODE_BCN_TX) begin
                beacon_neighbor_r <= upstream_neighbor_address_r;
            end
            // Claim history and loss cause live for one contention episode
            if (!is_contend(mode_nxt)) begin
                claim_seen_r <= 1'b0;
            end else if (rx_claim) begin
                claim_seen_r <= 1'b1;
            end
            if (line_loss && (mode_r == `MODE_REPEAT || mode_r == `MODE_IDLE_TX)) begin
                loss_cause_r <= 1'b1;
            end else if (!is_contend(mode_nxt)) begin
                loss_cause_r <= 1'b0;
            end
        end
    end

    // ****************************************************
    // Transmit path controls, all registered
    // ****************************************************
    always @(posedge sys_clk) begin
        if (!resetn) begin
            send_idle_r <= 1'b0;
            send_claim_r <= 1'b0;
            send_beacon_r <= 1'b0;
            repeat_en_r <= 1'b1;
            strip_frame_r <= 1'b0;
            purge_accept_r <= 1'b0;
            ring_insert_r <= 1'b1;
            run_selftest_r <= 1'b0;
            signal_loss_r <= 1'b0;
        end else begin
            send_idle_r <= (mode_nxt == `MODE_IDLE_TX);
            send_claim_r <= (mode_nxt == `MODE_CONT_TX);
            send_beacon_r <= (mode_nxt == `MODE_BCN_TX);
            repeat_en_r <= (mode_nxt == `MODE_REPEAT) || (mode_nxt == `MODE_CONT_RX) ||
                (mode_nxt == `MODE_BCN_RX);
            // Own frames are removed rather than repeated
            strip_frame_r <= rx_own_frame && ring_insert_r;
            purge_accept_r <= rx_purge && (mode_r != `MODE_CONT_TX);
            ring_insert_r <= (mode_nxt != `MODE_REMOVED) && (mode_nxt != `MODE_SELFTEST);
            run_selftest_r <= (mode_nxt == `MODE_SELFTEST);
            signal_loss_r <= line_loss;
        end
    end

endmodule
`default_nettype wire

/* File: sim/ring_beacon_checker_assertions.sv */
// Checker for the ring beacon recovery control.
// Assumes it is bound to ring_beacon_recovery and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module ring_beacon_checker #(
    parameter int SILENCE_CYC = 200,
    parameter int CONTEND_CYC = 500
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic rx_beacon,
    input wire logic [15:0] rx_beacon_type,
    input wire logic rx_beacon_own,
    input wire logic rx_purge,
    input wire logic rx_own_frame,
    input wire logic stream_err,
    input wire logic claim_stream_err,
    input wire logic tx_remove,
    input wire logic [2:0] mode_r,
    input wire logic send_idle_r,
    input wire logic send_claim_r,
    input wire logic send_beacon_r,
    input wire logic repeat_en_r,
    input wire logic strip_frame_r,
    input wire logic purge_accept_r,
    input wire logic ring_insert_r,
    input wire logic [15:0] beacon_type_r
);
    // ****
    // Dwell counters
    // ****
    logic [31:0] cont_cnt_r;
    logic [31:0] sil_cnt_r;
    // Counted here since the dwell is far beyond a repetition count
    always @(posedge sys_clk) begin
        // Both contention modes share one watchdog, so both count
        cont_cnt_r <= (!resetn || mode_r[2:1] != 2'b01) ? 32'h0 : cont_cnt_r + 32'h1;
        sil_cnt_r <= (!resetn || mode_r != 3'h5 || rx_beacon) ? 32'h0 : sil_cnt_r + 32'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ****
    // Properties
    // ****
    a_idle_send: assert property (mode_r == 3'h1 |-> send_idle_r && !repeat_en_r)
        else $error("idle mode without idle send");
    a_claim_send: assert property (mode_r == 3'h2 |-> send_claim_r && !send_beacon_r)
        else $error("contention without claim send");
    a_beacon_hold: assert property (mode_r == 3'h4 |-> send_beacon_r && !repeat_en_r)
        else $error("beacon mode without beacon send");
    a_remove_out: assert property (mode_r == 3'h4 && tx_remove
        |=> mode_r == 3'h6 && !ring_insert_r)
        else $error("transmit removal not taken");
    a_stream_entry: assert property (mode_r == 3'h0 && stream_err && !claim_stream_err
        |=> mode_r != 3'h0 && (mode_r != 3'h4 || beacon_type_r == 16'h0003))
        else $error("streaming error beacon wrong");
    a_claim_entry: assert property (mode_r == 3'h0 && claim_stream_err
        |=> mode_r != 3'h0 && (mode_r != 3'h4 || beacon_type_r == 16'h0004))
        else $error("claim streaming beacon wrong");
    a_own_return: assert property (mode_r == 3'h4 && rx_beacon && rx_beacon_own
        && !tx_remove |=> mode_r == 3'h2)
        else $error("own beacon did not start contention");
    a_lower_repeat: assert property (mode_r == 3'h4 && rx_beacon && !rx_beacon_own
        && !tx_remove && rx_beacon_type <= beacon_type_r |=> mode_r == 3'h5)
        else $error("lower or equal beacon not repeated");
    a_keep_high: assert property (mode_r == 3'h4 && rx_beacon && !rx_beacon_own
        && !tx_remove && rx_beacon_type > beacon_type_r |=> $stable(mode_r))
        else $error("higher beacon stopped beaconing");
    a_purge_block: assert property (mode_r == 3'h2 && rx_purge |=> !purge_accept_r)
        else $error("purge accepted in contention");
    a_strip_own: assert property (rx_own_frame && ring_insert_r |=> strip_frame_r)
        else $error("own frame not stripped");
    a_watchdog_bound: assert property (cont_cnt_r <= CONTEND_CYC + 2)
        else $error("contention outlived its watchdog");
    a_silence_bound: assert property (sil_cnt_r <= SILENCE_CYC + 2)
        else $error("beacon repeat outlived silence");
    cover property (mode_r == 3'h4 && beacon_type_r == 16'h0002);
    cover property (mode_r == 3'h5);
    cover property (mode_r == 3'h1);
endmodule
bind ring_beacon_recovery ring_beacon_checker #(.SILENCE_CYC(SILENCE_CYC),
    .CONTEND_CYC(CONTEND_CYC)) u_chk (.sys_clk, .resetn, .rx_beacon, .rx_beacon_type,
    .rx_beacon_own, .rx_purge, .rx_own_frame, .stream_err, .claim_stream_err, .tx_remove,
    .mode_r, .send_idle_r, .send_claim_r, .send_beacon_r, .repeat_en_r, .strip_frame_r,
    .purge_accept_r, .ring_insert_r, .beacon_type_r);
`default_nettype wire

/* File: sim/ring_peer_model.sv */
// Peer stations on the ring, seen as recovered bit clock and data.
// Assumes the bench asks for a stalled line through hold_data.
`timescale 1ns/100ps
`default_nettype none
module ring_peer_model (
    input wire logic hold_data,
    output logic rx_clk,
    output logic rx_data
);
    // ****
    // Ring line
    // ****
    // Clock runs free: an inserted ring is never silent
    // Data moves on the falling half so the rising edge sees it settled
    initial begin
        rx_clk = 1'b0;
        rx_data = 1'b0;
        forever begin
            #400;
            rx_clk = ~rx_clk;
            if (!rx_clk && !hold_data) begin
                rx_data = ~rx_data;
            end
        end
    end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the ring beacon recovery control.
// Assumes the peer model drives the line and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int SIL = 200;
    localparam int CON = 500;
    localparam int BCN = 0, CLM = 1, PRG = 2, OWNF = 3, CST = 4, WON = 5, STR = 6;
    localparam int CSE = 7, ULD = 8, TXR = 9, RXR = 10, STD = 11, RIN = 12;
    logic sys_clk, resetn, hold_data, rx_beacon_own, selftest_pass;
    logic [12:0] pls;
    logic [15:0] rx_beacon_type, beacon_type_r;
    logic [47:0] neighbor_in, beacon_neighbor_r;
    logic [2:0] mode_r;
    logic send_idle_r, send_claim_r, send_beacon_r, repeat_en_r, strip_frame_r;
    logic purge_accept_r, ring_insert_r, run_selftest_r, signal_loss_r;
    wire logic rx_clk, rx_data, rx_beacon, rx_claim, rx_purge, rx_own_frame, contend_start;
    wire logic contend_won, stream_err, claim_stream_err, neighbor_load, tx_remove, rx_remove;
    wire logic selftest_done, reinsert_req;
    int bad_count, samples_checked, n;
    // One vector carries every event pulse, so clearing is a single step
    assign {reinsert_req, selftest_done, rx_remove, tx_remove, neighbor_load, claim_stream_err,
        stream_err, contend_won, contend_start, rx_own_frame, rx_purge, rx_claim,
        rx_beacon} = pls;
    ring_peer_model i_peer (.hold_data, .rx_clk, .rx_data);
    ring_beacon_recovery #(.SILENCE_CYC(SIL), .CONTEND_CYC(CON)) i_dut (.sys_clk, .resetn,
        .rx_clk, .rx_data, .rx_beacon, .rx_beacon_type, .rx_beacon_own, .rx_claim,
        .rx_purge, .rx_own_frame, .contend_start, .contend_won, .stream_err,
        .claim_stream_err, .neighbor_load, .neighbor_in, .tx_remove, .rx_remove, .selftest_done,
        .selftest_pass, .reinsert_req, .mode_r, .send_idle_r, .send_claim_r,
        .send_beacon_r, .repeat_en_r, .strip_frame_r, .purge_accept_r, .ring_insert_r,
        .run_selftest_r, .signal_loss_r, .beacon_type_r, .beacon_neighbor_r);
    // ****
    // Shared tasks
    // ****
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    // Pulse for one cycle, then look just after the edge that took it
    task automatic fire(input int k);
        @(posedge sys_clk);
        pls <= 13'h0001 << k;
        @(posedge sys_clk);
        pls <= 13'h0000;
        #1;
    endtask
    task automatic bcn(input logic [15:0] typ, input logic own);
        @(posedge sys_clk);
        rx_beacon_type <= typ;
        rx_beacon_own <= own;
        fire(BCN);
    endtask
    task automatic wm(input logic [2:0] m, input int lim);
        n = 0;
        while (mode_r !== m && n < lim) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk("mode", 48'(m), 48'(mode_r));
    endtask
    task automatic near(input int want);
        chk("dwell", 48'h1, 48'(n >= want - 4 && n <= want + 2));
    endtask
    task automatic home;
        fire(TXR);
        chk("mode", 48'h6, 48'(mode_r));
        chk("insert", 48'h0, 48'(ring_insert_r));
        fire(RIN);
        chk("selftest", 48'h1, 48'(run_selftest_r));
        fire(STD);
        chk("mode", 48'h0, 48'(mode_r));
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_stream;
        fire(ULD);
        fire(STR);
        chk("mode", 48'h4, 48'(mode_r));
        chk("type", 48'h3, 48'(beacon_type_r));
        chk("neighbor", neighbor_in, beacon_neighbor_r);
        repeat (20) @(posedge sys_clk);
        chk("beacon", 48'h1, 48'(send_beacon_r && mode_r === 3'h4));
        home();
        $display("t_stream done");
    endtask
    task automatic t_claim;
        fire(CSE);
        chk("type", 48'h4, 48'(beacon_type_r));
        chk("neighbor", neighbor_in, beacon_neighbor_r);
        bcn(16'h0004, 1'b1);
        chk("mode", 48'h2, 48'(mode_r));
        fire(PRG);
        chk("purge", 48'h0, 48'(purge_accept_r));
        fire(WON);
        fire(PRG);
        chk("purge", 48'h1, 48'(purge_accept_r));
        $display("t_claim done");
    endtask
    task automatic t_compare;
        fire(STR);
        bcn(16'h0004, 1'b0);
        chk("mode", 48'h4, 48'(mode_r));
        bcn(16'h0003, 1'b0);
        chk("mode", 48'h5, 48'(mode_r));
        repeat (50) @(posedge sys_clk);
        bcn(16'h0003, 1'b0);
        wm(3'h2, SIL + 10);
        near(SIL);
        fire(CLM);
        wm(3'h4, CON + 10);
        near(CON - 2);
        chk("type", 48'h4, 48'(beacon_type_r));
        bcn(16'h0002, 1'b0);
        chk("mode", 48'h5, 48'(mode_r));
        fire(RXR);
        chk("selftest", 48'h1, 48'(run_selftest_r));
        fire(STD);
        chk("mode", 48'h0, 48'(mode_r));
        $display("t_compare done");
    endtask
    task automatic t_timeout;
        fire(CST);
        chk("claim", 48'h1, 48'(send_claim_r));
        wm(3'h4, CON + 10);
        near(CON);
        chk("type", 48'h3, 48'(beacon_type_r));
        home();
        fire(OWNF);
        chk("strip", 48'h1, 48'(strip_frame_r));
        fire(CLM);
        chk("strip", 48'h0, 48'(strip_frame_r));
        chk("mode", 48'h3, 48'(mode_r));
        chk("repeat", 48'h1, 48'(repeat_en_r));
        // Leave contention repeat so the next test starts from plain repeat
        fire(WON);
        chk("mode", 48'h0, 48'(mode_r));
        $display("t_timeout done");
    endtask
    task automatic t_loss;
        @(posedge sys_clk);
        hold_data <= 1'b1;
        wm(3'h1, 300);
        chk("idle", 48'h1, 48'(send_idle_r));
        wm(3'h2, 400);
        chk("claim", 48'h1, 48'(send_claim_r));
        chk("loss", 48'h1, 48'(signal_loss_r));
        @(posedge sys_clk);
        hold_data <= 1'b0;
        wm(3'h4, CON + 50);
        chk("type", 48'h2, 48'(beacon_type_r));
        chk("loss", 48'h0, 48'(signal_loss_r));
        home();
        $display("t_loss done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****
    // Clock, watchdog and main sequence
    // ****
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Tests need well under a millisecond of simulated time
    initial begin
        #2000000;
        bad_count++;
        test_done();
    end
    initial begin
        {resetn, hold_data, rx_beacon_own, pls, rx_beacon_type} = '0;
        selftest_pass = 1'b1;
        neighbor_in = 48'h0A1B2C3D4E5F;
        bad_count = 0;
        samples_checked = 0;
        repeat (8) @(posedge sys_clk);
        #1;
        chk("mode", 48'h0, 48'(mode_r));
        chk("repeat", 48'h1, 48'(repeat_en_r && ring_insert_r));
        @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (40) @(posedge sys_clk);
        t_stream();
        t_claim();
        t_compare();
        t_timeout();
        t_loss();
        test_done();
    end
endmodule
`default_nettype wire
